// *** shared/isc_map.svh ***
// register map, field positions, reset values and counts of the classifier
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH

// source counts and widths
`define ISC_NUM_SRC 44
`define ISC_NUM_SPECIAL 9
`define ISC_NUM_EXT 6
`define ISC_NUM_KEY 4
`define ISC_NUM_SER 3
`define ISC_SRC_LOW_FREE 34

// software numbers that switch to the interrupt stack
`define ISC_SOFT_ISP_MAX 6'h1F

// flag_register bit positions
`define ISC_FLG_O 2
`define ISC_FLG_D 5
`define ISC_FLG_I 6
`define ISC_FLG_U 7
`define ISC_FLG_IPL 14:12

// fast path
`define ISC_FAST_LVL 3'h7
`define ISC_FAST_ENTRY_CYC 3'h5
`define ISC_FAST_RET_CYC 3'h3

// pin sense modes
`define ISC_PM_RISE 3'h0
`define ISC_PM_FALL 3'h1
`define ISC_PM_BOTH 3'h2
`define ISC_PM_HIGH 3'h3
`define ISC_PM_LOW 3'h4

// byte addresses
`define ISC_A_CTRL 8'h00
`define ISC_A_EXIT_PRIO 8'h04
`define ISC_A_AMATCH 8'h08
`define ISC_A_FVECT 8'h0C
`define ISC_A_LEVEL 8'h10
`define ISC_A_PIN_MODE 8'h14
`define ISC_A_SER_MODE 8'h18
`define ISC_A_STATUS 8'h1C
`define ISC_A_PEND_LO 8'h20
`define ISC_A_PEND_HI 8'h24

// field positions
`define ISC_CTRL_AMEN 0
`define ISC_EXIT_FAST 3
`define ISC_LEVEL_IDX 5:0
`define ISC_LEVEL_LVL 10:8
`define ISC_SER_I2C 2:0
`define ISC_SER_SS 6:4

// reset values
`define ISC_RST_ADDR 24'h000000
`define ISC_RST_PIN_MODE 18'h00000
`define ISC_RST_LVL 3'h0
`endif

// *** shared/isc_pkg.sv ***
// types shared by the interrupt source classifier
package isc_pkg;
   typedef enum logic [2:0] {
      INS_NONE, INS_UND, INS_BRK, INS_DEBUGGER_BREAK_INSTR, INS_INTO, INS_INT, INS_FAST_RETURN_INSTR
   } isc_instr_type;

   typedef struct packed {
      logic done;
      isc_instr_type kind;
      logic [5:0] num;
   } isc_exec_type;

   typedef enum logic [1:0] {CLS_SPECIAL, CLS_SOFT, CLS_PERIPH} isc_class_type;

   typedef enum logic [3:0] {
      SP_RESET, SP_NMI, SP_WDT, SP_UND, SP_INTO, SP_BRK, SP_DEBUGGER_BREAK_INSTR, SP_AMATCH, SP_STEP
   } isc_special_type;

   typedef struct packed {
      logic valid;
      isc_class_type cls;
      logic [5:0] num;
      logic save_u;
      logic nonmask;
   } isc_irq_type;

   typedef enum logic [1:0] {
      ST_IDLE, ST_FAST_ENTRY, ST_FAST_RUN, ST_FAST_RET
   } isc_state_type;
endpackage

// *** core/isc_pin_sense.sv ***
// one interrupt pin: two-flop synchroniser and edge or level sensing
`timescale 1ns/1ps
`include "isc_map.svh"
module isc_pin_sense (
   // clock
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // pin and selection
   input wire logic pin,
   input wire logic [2:0] mode,
   // request
   output logic req
);
   logic sync1;
   logic sync2;
   logic last;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         last <= 1'b1;
      end else if (ce) begin
         sync1 <= pin;
         sync2 <= sync1;
         last <= sync2;
      end
   end

   wire rise = sync2 & ~last;
   wire fall = ~sync2 & last;

   always_comb begin
      case (mode)
         `ISC_PM_RISE: req = rise;
         `ISC_PM_FALL: req = fall;
         `ISC_PM_BOTH: req = rise | fall;
         `ISC_PM_HIGH: req = sync2;
         `ISC_PM_LOW: req = ~sync2;
         default: req = 1'b0;
      endcase
   end
endmodule

// *** core/isc_classifier.sv ***
// interrupt source classifier: classes, arbitration, stack select, fast path
// Operation
// R01: maskable requests need the enable flag and win by level; non-maskable bypass both
// R02: instruction-raised interrupts ignore the enable flag
// R03: undefined-opcode, break and debugger break each raise their own interrupt
// R04: overflow trap raises only when the overflow flag is 1
// R05: software interrupt takes numbers 0 to 63; 0 to 43 share peripheral vectors
// R06: software numbers 0 to 31 save and clear stack-select, restored on return
// R07: software numbers 32 to 63 leave stack-select alone
// R08: peripheral interrupts always save and clear stack-select; the fast path only copies flags and PC to the shadows and clears nothing
// R09: reset pin, interrupt pin, watchdog, address match, single step are non-maskable
// R10: with match enabled, execution address equal to match register raises interrupt
// R11: match fires only on instruction start addresses
// R12: debug-step flag set raises single step after every instruction
// R13: peripheral interrupts are maskable and use vectors 0 to 43
// R14: serial shared interrupt: start/stop in I2C mode, fault with slave select
// R15: low level on any key input raises the key interrupt
// R16: external pins sense rising, falling, both edges, or high or low level
// R17: fast entry completes within 5 cycles, return within 3
// R18: fast entry copies flags and PC to shadows, fetches from fast vector
// R19: fast return restores flags and PC from the shadows
// R20: exit priority bit 3 set routes the level 7 interrupt through fast path
// R21: software sets only one interrupt to level 7 when using the fast path
// R22: with fast path enabled, software uses at most two DMA channels
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "isc_map.svh"
module isc_classifier
   import isc_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // cpu core side
   input wire isc_exec_type exec_i,
   input wire logic [15:0] flag_register,
   input wire logic [23:0] cpu_pc,
   input wire logic instr_start,
   input wire logic [23:0] fetch_addr,
   input wire logic irq_ack,
   output isc_irq_type irq_o,
   output logic fast_entry,
   output logic [23:0] fast_fetch_addr,
   output logic [15:0] shadow_flag_register,
   output logic [23:0] shadow_pc_register,
   output logic fast_restore,
   // on-chip sources
   input wire logic wdt_timeout,
   input wire logic [`ISC_NUM_SRC-1:0] periph_req,
   input wire logic [`ISC_NUM_SER-1:0] ser_collision,
   input wire logic [`ISC_NUM_SER-1:0] ser_start,
   input wire logic [`ISC_NUM_SER-1:0] ser_stop,
   input wire logic [`ISC_NUM_SER-1:0] ser_fault,
   // pins
   input wire logic reset_pin_n,
   input wire logic nmi_pin_n,
   input wire logic [`ISC_NUM_KEY-1:0] key_input_pin_n,
   input wire logic [`ISC_NUM_EXT-1:0] ext_int_pin
);
   // software registers
   logic amen;
   logic fast_en;
   logic [23:0] amatch;
   logic [23:0] fast_vector_register;
   logic [17:0] pin_mode;
   logic [2:0] ser_i2c;
   logic [2:0] ser_ss;
   logic [5:0] lvl_sel;
   logic [2:0] level_mem [0:`ISC_NUM_SRC-1];

   // pending state
   logic [`ISC_NUM_SPECIAL-1:0] sp_pend;
   logic [`ISC_NUM_SRC-1:0] pr_pend;
   logic soft_pend;
   logic [5:0] soft_num;
   isc_state_type state;
   logic [2:0] cnt;

   // pin sensing
   logic rst_req;
   logic nmi_req;
   logic [`ISC_NUM_KEY-1:0] key_lvl;
   logic [`ISC_NUM_EXT-1:0] ext_req;

   isc_pin_sense u_rst_pin (
      .clk(clk), .reset(reset), .ce(ce),
      .pin(reset_pin_n), .mode(`ISC_PM_LOW), .req(rst_req)
   );
   isc_pin_sense u_nmi_pin (
      .clk(clk), .reset(reset), .ce(ce),
      .pin(nmi_pin_n), .mode(`ISC_PM_LOW), .req(nmi_req)
   );
   for (genvar k = 0; k < `ISC_NUM_KEY; k++) begin : g_key
      isc_pin_sense u_key (
         .clk(clk), .reset(reset), .ce(ce),
         .pin(key_input_pin_n[k]), .mode(`ISC_PM_LOW), .req(key_lvl[k])
      );
   end
   for (genvar e = 0; e < `ISC_NUM_EXT; e++) begin : g_ext
      // R16
      isc_pin_sense u_ext (
         .clk(clk), .reset(reset), .ce(ce),
         .pin(ext_int_pin[e]), .mode(pin_mode[3*e +: 3]), .req(ext_req[e])
      );
   end

   wire key_req = |key_lvl; // R15
   // the bus collision detector is the default, the mode bits repurpose it
   wire [2:0] ser_req = (ser_i2c & (ser_start | ser_stop))
      | (~ser_i2c & ser_ss & ser_fault)
      | (~ser_i2c & ~ser_ss & ser_collision); // R14
   wire [`ISC_NUM_SRC-1:0] pr_set = periph_req
      | {ext_req, key_req, ser_req, {`ISC_SRC_LOW_FREE{1'b0}}}; // R13

   // special sources, all non-maskable
   wire ex_und = exec_i.done & (exec_i.kind == INS_UND);
   wire ex_brk = exec_i.done & (exec_i.kind == INS_BRK);
   wire ex_debugger_break_instr = exec_i.done & (exec_i.kind == INS_DEBUGGER_BREAK_INSTR);
   wire ex_into = exec_i.done & (exec_i.kind == INS_INTO);
   wire ex_int = exec_i.done & (exec_i.kind == INS_INT);
   wire ex_fast_return_instr = exec_i.done & (exec_i.kind == INS_FAST_RETURN_INSTR);
   // compared only at instruction starts, so a mid-instruction value never hits
   wire am_hit = instr_start & amen & (fetch_addr == amatch); // R10 R11
   logic [`ISC_NUM_SPECIAL-1:0] sp_set;
   always_comb begin
      sp_set = '0;
      sp_set[SP_RESET] = rst_req; // R09
      sp_set[SP_NMI] = nmi_req; // R09
      sp_set[SP_WDT] = wdt_timeout; // R09
      sp_set[SP_UND] = ex_und; // R03
      sp_set[SP_INTO] = ex_into & flag_register[`ISC_FLG_O]; // R04
      sp_set[SP_BRK] = ex_brk; // R03
      sp_set[SP_DEBUGGER_BREAK_INSTR] = ex_debugger_break_instr; // R03
      sp_set[SP_AMATCH] = am_hit; // R09
      sp_set[SP_STEP] = exec_i.done & flag_register[`ISC_FLG_D]; // R12
   end

   // lowest index special wins
   logic sp_hit;
   logic [3:0] sp_idx;
   always_comb begin
      sp_hit = 1'b0;
      sp_idx = '0;
      for (int i = `ISC_NUM_SPECIAL - 1; i >= 0; i--) begin
         if (sp_pend[i]) begin
            sp_hit = 1'b1;
            sp_idx = i[3:0];
         end
      end
   end

   // peripheral arbitration: highest level, lowest number on a tie; level 0 never wins
   logic pr_hit;
   logic [5:0] pr_idx;
   logic [2:0] pr_lvl;
   always_comb begin
      pr_hit = 1'b0;
      pr_idx = '0;
      pr_lvl = '0;
      for (int i = 0; i < `ISC_NUM_SRC; i++) begin
         if (pr_pend[i] && (level_mem[i] > pr_lvl)) begin // R01
            pr_hit = 1'b1;
            pr_idx = i[5:0];
            pr_lvl = level_mem[i];
         end
      end
   end

   wire can_issue = (state == ST_IDLE) & ~irq_o.valid;
   wire iss_sp = can_issue & sp_hit; // R02 R09
   wire iss_soft = can_issue & ~sp_hit & soft_pend;
   wire mask_ok = pr_hit & flag_register[`ISC_FLG_I]
      & (pr_lvl > flag_register[`ISC_FLG_IPL]); // R01
   wire iss_pr = can_issue & ~sp_hit & ~soft_pend & mask_ok;
   wire go_fast = iss_pr & fast_en & (pr_lvl == `ISC_FAST_LVL); // R20

   logic [`ISC_NUM_SPECIAL-1:0] sp_clr;
   logic [`ISC_NUM_SRC-1:0] pr_clr;
   always_comb begin
      sp_clr = '0;
      pr_clr = '0;
      if (iss_sp) begin
         sp_clr[sp_idx] = 1'b1;
      end
      if (iss_pr) begin
         pr_clr[pr_idx] = 1'b1;
      end
   end

   isc_irq_type next_irq;
   always_comb begin
      next_irq = irq_o;
      if (iss_sp) begin
         next_irq = '{1'b1, CLS_SPECIAL, {2'h0, sp_idx}, 1'b1, 1'b1};
      end else if (iss_soft) begin
         next_irq = '{1'b1, CLS_SOFT, soft_num,
            soft_num <= `ISC_SOFT_ISP_MAX, 1'b1}; // R02 R05 R06 R07
      end else if (iss_pr && !go_fast) begin
         next_irq = '{1'b1, CLS_PERIPH, pr_idx, 1'b1, 1'b0}; // R08 R13
      end else if (irq_ack) begin
         next_irq.valid = 1'b0;
      end
   end

   // pending flags: a set in the clearing cycle wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sp_pend <= '0;
         pr_pend <= '0;
         soft_pend <= 1'b0;
         soft_num <= '0;
         irq_o <= '0;
      end else if (ce) begin
         sp_pend <= (sp_pend & ~sp_clr) | sp_set;
         pr_pend <= (pr_pend & ~pr_clr) | pr_set;
         soft_pend <= ex_int | (soft_pend & ~iss_soft); // R05
         if (ex_int) begin
            soft_num <= exec_i.num;
         end
         irq_o <= next_irq;
      end
   end

   // fast path sequencer
   wire entry_end = (state == ST_FAST_ENTRY) & (cnt == `ISC_FAST_ENTRY_CYC - 3'h1);
   wire ret_end = (state == ST_FAST_RET) & (cnt == `ISC_FAST_RET_CYC - 3'h1);
   isc_state_type next_state;
   always_comb begin
      case (state)
         ST_IDLE: next_state = go_fast ? ST_FAST_ENTRY : ST_IDLE;
         ST_FAST_ENTRY: next_state = entry_end ? ST_FAST_RUN : ST_FAST_ENTRY;
         ST_FAST_RUN: next_state = ex_fast_return_instr ? ST_FAST_RET : ST_FAST_RUN;
         ST_FAST_RET: next_state = ret_end ? ST_IDLE : ST_FAST_RET;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         cnt <= '0;
         fast_entry <= 1'b0;
         fast_restore <= 1'b0;
         fast_fetch_addr <= `ISC_RST_ADDR;
         shadow_flag_register <= '0;
         shadow_pc_register <= `ISC_RST_ADDR;
      end else if (ce) begin
         state <= next_state;
         cnt <= (next_state != state) ? 3'h1 : cnt + 3'h1; // R17
         fast_entry <= entry_end; // R17
         fast_restore <= ret_end; // R17 R19
         if (go_fast) begin
            shadow_flag_register <= flag_register; // R18
            shadow_pc_register <= cpu_pc; // R18
         end
         if (entry_end) begin
            fast_fetch_addr <= fast_vector_register; // R18
         end
      end
   end

   // wishbone slave: ack one cycle after the strobe, dropped the next cycle
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i;
   wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire hit_ctrl = wb_adr_i == `ISC_A_CTRL;
   wire hit_exit = wb_adr_i == `ISC_A_EXIT_PRIO;
   wire hit_am = wb_adr_i == `ISC_A_AMATCH;
   wire hit_fv = wb_adr_i == `ISC_A_FVECT;
   wire hit_lvl = wb_adr_i == `ISC_A_LEVEL;
   wire hit_pm = wb_adr_i == `ISC_A_PIN_MODE;
   wire hit_ser = wb_adr_i == `ISC_A_SER_MODE;
   wire hit_st = wb_adr_i == `ISC_A_STATUS;
   wire hit_plo = wb_adr_i == `ISC_A_PEND_LO;
   wire hit_phi = wb_adr_i == `ISC_A_PEND_HI;

   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~wmask) | (wb_dat_i & wmask);
   endfunction

   wire [31:0] ctrl_img = {31'h0, amen};
   wire [31:0] exit_img = {28'h0, fast_en, 3'h0};
   wire [31:0] ser_img = {25'h0, ser_ss, 1'h0, ser_i2c};
   wire [5:0] wr_idx = wb_dat_i[`ISC_LEVEL_IDX];
   wire lvl_wr = wb_wr & hit_lvl & wb_sel_i[0] & wb_sel_i[1];
   wire lvl_in = lvl_sel < `ISC_NUM_SRC;
   wire [2:0] lvl_rd = lvl_in ? level_mem[lvl_sel] : `ISC_RST_LVL;
   wire [31:0] st_img = {21'h0, state == ST_FAST_RUN, irq_o.valid, sp_pend};
   wire [31:0] rd_data =
      hit_ctrl ? ctrl_img :
      hit_exit ? exit_img :
      hit_am ? {8'h0, amatch} :
      hit_fv ? {8'h0, fast_vector_register} :
      hit_lvl ? {21'h0, lvl_rd, 2'h0, lvl_sel} :
      hit_pm ? {14'h0, pin_mode} :
      hit_ser ? ser_img :
      hit_st ? st_img :
      hit_plo ? pr_pend[31:0] :
      hit_phi ? {20'h0, pr_pend[`ISC_NUM_SRC-1:32]} :
      32'h0;

   logic [31:0] m_ctrl;
   logic [31:0] m_exit;
   logic [31:0] m_am;
   logic [31:0] m_fv;
   logic [31:0] m_pm;
   logic [31:0] m_ser;
   assign m_ctrl = merge(ctrl_img);
   assign m_exit = merge(exit_img);
   assign m_am = merge({8'h0, amatch});
   assign m_fv = merge({8'h0, fast_vector_register});
   assign m_pm = merge({14'h0, pin_mode});
   assign m_ser = merge(ser_img);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (ce) begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? rd_data : 32'h0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         amen <= 1'b0;
         fast_en <= 1'b0;
         amatch <= `ISC_RST_ADDR;
         fast_vector_register <= `ISC_RST_ADDR;
         pin_mode <= `ISC_RST_PIN_MODE;
         ser_i2c <= '0;
         ser_ss <= '0;
         lvl_sel <= '0;
      end else if (ce && wb_wr) begin
         if (hit_ctrl) amen <= m_ctrl[`ISC_CTRL_AMEN];
         if (hit_exit) fast_en <= m_exit[`ISC_EXIT_FAST]; // R20
         if (hit_am) amatch <= m_am[23:0];
         if (hit_fv) fast_vector_register <= m_fv[23:0];
         if (hit_pm) pin_mode <= m_pm[17:0];
         if (hit_ser) ser_i2c <= m_ser[`ISC_SER_I2C];
         if (hit_ser) ser_ss <= m_ser[`ISC_SER_SS];
         if (hit_lvl && wb_sel_i[0]) lvl_sel <= wr_idx;
      end
   end

   // levels live in a small array; one source is written per access
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < `ISC_NUM_SRC; i++) begin
            level_mem[i] <= `ISC_RST_LVL;
         end
      end else if (ce && lvl_wr && (wr_idx < `ISC_NUM_SRC)) begin
         level_mem[wr_idx] <= wb_dat_i[`ISC_LEVEL_LVL];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset || !ce);

   chk_mask_gate: assert property ( // R01
      $rose(irq_o.valid) && irq_o.cls == CLS_PERIPH |-> $past(flag_register[`ISC_FLG_I])
   ) else $error("peripheral issued with enable flag clear");
   chk_soft_nonmask: assert property ( // R02
      $rose(irq_o.valid) && irq_o.cls != CLS_PERIPH |-> irq_o.nonmask
   ) else $error("instruction interrupt marked maskable");
   chk_und_trap: assert property ( // R03
      ex_und |=> sp_pend[SP_UND]
   ) else $error("undefined opcode trap not raised");
   chk_into_gate: assert property ( // R04
      ex_into && !flag_register[`ISC_FLG_O] && !sp_pend[SP_INTO] |=> !sp_pend[SP_INTO]
   ) else $error("overflow trap raised with flag clear");
   chk_soft_stack: assert property ( // R06
      $rose(irq_o.valid) && irq_o.cls == CLS_SOFT
      |-> irq_o.save_u == (irq_o.num <= `ISC_SOFT_ISP_MAX)
   ) else $error("software stack select wrong");
   chk_periph_stack: assert property ( // R08
      $rose(irq_o.valid) && irq_o.cls == CLS_PERIPH |-> irq_o.save_u
   ) else $error("peripheral did not select interrupt stack");
   chk_addr_match: assert property ( // R10
      am_hit |=> sp_pend[SP_AMATCH]
   ) else $error("address match missed");
   chk_single_step: assert property ( // R12
      exec_i.done && flag_register[`ISC_FLG_D] |=> sp_pend[SP_STEP]
   ) else $error("single step missed");
   chk_fast_entry: assert property ( // R17
      $rose(state == ST_FAST_ENTRY) |-> !fast_entry [*4] ##1 fast_entry
   ) else $error("fast entry not at fifth cycle");
   chk_fast_shadow: assert property ( // R18
      $rose(state == ST_FAST_ENTRY)
      |-> shadow_flag_register == $past(flag_register) && $past(fast_en)
   ) else $error("shadow flags not captured");
   chk_fast_return: assert property ( // R19
      state == ST_FAST_RUN && ex_fast_return_instr |-> ##3 fast_restore
   ) else $error("fast return late");
endmodule

// *** dv/isc_cpu_model.sv ***
// cpu core model: takes interrupts after a set delay and restores fast shadows
`timescale 1ns/1ps
module isc_cpu_model
   import isc_pkg::*;
(
   // clock
   input wire logic clk,
   input wire logic reset,
   // classifier side
   input wire isc_irq_type irq_o,
   input wire logic fast_restore,
   input wire logic [15:0] shadow_flag_register,
   input wire logic [23:0] shadow_pc_register,
   output logic irq_ack,
   // bench side
   input wire logic [3:0] ack_delay,
   output logic taken,
   output isc_irq_type taken_irq,
   output logic [15:0] restored_flag,
   output logic [23:0] restored_pc
);
   logic [3:0] wait_cnt;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_ack <= 1'b0;
         taken <= 1'b0;
         taken_irq <= '0;
         wait_cnt <= 4'h0;
         restored_flag <= 16'h0000;
         restored_pc <= 24'h000000;
      end else begin
         irq_ack <= 1'b0;
         taken <= 1'b0;
         // a slow core leaves the request standing for ack_delay cycles
         if (irq_o.valid && !irq_ack) begin
            if (wait_cnt >= ack_delay) begin
               irq_ack <= 1'b1;
               taken <= 1'b1;
               taken_irq <= irq_o;
               wait_cnt <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
         if (fast_restore) begin
            restored_flag <= shadow_flag_register;
            restored_pc <= shadow_pc_register;
         end
      end
   end
endmodule

// *** dv/isc_classifier_tb_top.sv ***
// self-checking bench of the interrupt source classifier
`timescale 1ns/1ps
`include "isc_map.svh"
module isc_classifier_tb_top;
   import isc_pkg::*;
   logic clk, reset, cyc, stb, we, istart, rst_pin_n, nmi_n, wdt, wb_ack_o, irq_ack, taken;
   logic fast_entry, fast_restore, p;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, seed, wb_dat_o;
   logic [15:0] flag, fl, sflag, rflag;
   logic [23:0] pc, pcv, faddr, fetch, ffa, spc, rpc;
   logic [5:0] ext, x;
   logic [3:0] key_n, dly;
   logic [`ISC_NUM_SER-1:0] s_start, s_stop, s_fault;
   logic [`ISC_NUM_SRC-1:0] preq;
   isc_exec_type exec;
   isc_irq_type irq_o, taken_irq;
   int errors, n_tests, cycles, k, k2, n;

   isc_classifier isc_classifier_i(.clk(clk), .reset(reset), .ce(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exec_i(exec), .flag_register(flag),
      .cpu_pc(pc), .instr_start(istart), .fetch_addr(fetch), .irq_ack(irq_ack), .irq_o(irq_o),
      .fast_entry(fast_entry), .fast_fetch_addr(ffa), .shadow_flag_register(sflag),
      .shadow_pc_register(spc), .fast_restore(fast_restore), .wdt_timeout(wdt),
      .periph_req(preq), .ser_collision(3'h0), .ser_start(s_start), .ser_stop(s_stop),
      .ser_fault(s_fault), .reset_pin_n(rst_pin_n), .nmi_pin_n(nmi_n),
      .key_input_pin_n(key_n), .ext_int_pin(ext));
   isc_cpu_model isc_cpu_model_i(.clk(clk), .reset(reset), .irq_o(irq_o),
      .fast_restore(fast_restore), .shadow_flag_register(sflag), .shadow_pc_register(spc),
      .irq_ack(irq_ack), .ack_delay(dly), .taken(taken), .taken_irq(taken_irq),
      .restored_flag(rflag), .restored_pc(rpc));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (errors == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin @(posedge clk); t++; end while (wb_ack_o !== 1'b1 && t < 50);
      if (t >= 50) errors++;
      rdat = wb_dat_o;
      {cyc, stb, we} <= 3'b000;
      @(posedge clk);
   endtask
   task automatic take(input logic [1:0] c, input logic [5:0] nu, input logic su, input logic nm);
      int t;
      t = 0;
      do begin @(posedge clk); t++; end while (taken !== 1'b1 && t < 60);
      check({taken, taken_irq}, {2'b11, c, nu, su, nm});
   endtask
   task automatic quiet();
      logic s;
      s = 1'b0;
      repeat (20) begin @(posedge clk); if (irq_o.valid !== 1'b0) s = 1'b1; end
      check(s, 1'b0);
   endtask
   task automatic drain();
      int q;
      q = 0;
      repeat (200) begin
         @(posedge clk);
         q = (irq_o.valid === 1'b1) ? 0 : q + 1;
         if (q > 12) break;
      end
   endtask
   task automatic op(input isc_instr_type kd, input logic [5:0] nu);
      @(posedge clk);
      exec <= '{1'b1, kd, nu};
      @(posedge clk);
      exec <= '0;
   endtask
   task automatic ist(input logic [23:0] a);
      @(posedge clk);
      {istart, fetch} <= {1'b1, a};
      @(posedge clk);
      istart <= 1'b0;
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // hang guard: the whole sequence needs about a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end
   initial begin
      {reset, rst_pin_n, nmi_n, key_n, seed} = {3'b111, 4'hF, 32'h899A45D2};
      {cyc, stb, we, istart, wdt, adr, wdat, flag, pc, fetch, ext, dly} = '0;
      {s_start, s_stop, s_fault, preq, exec} = '0;
      repeat (6) @(posedge clk);
      check(irq_o.valid, 1'b0);
      reset <= 1'b0;
      faddr = rnd();
      wb(1, `ISC_A_AMATCH, {8'h00, faddr});
      wb(0, `ISC_A_AMATCH, 0);
      check(rdat, {8'h00, faddr});
      wb(1, 8'h30, 32'hFFFFFFFF);
      wb(0, 8'h30, 0);
      check(rdat, 32'h0);
      for (int i = 0; i < 10; i++) begin
         x = (i == 0) ? 6'h1F : (i == 1) ? 6'h20 : (i == 2) ? 6'h3F : rnd();
         dly <= rnd();
         op(INS_INT, x);
         take(CLS_SOFT, x, x <= `ISC_SOFT_ISP_MAX, 1'b1);
      end
      op(INS_UND, 0);
      take(CLS_SPECIAL, {2'b00, SP_UND}, 1'b1, 1'b1);
      op(INS_BRK, 0);
      take(CLS_SPECIAL, {2'b00, SP_BRK}, 1'b1, 1'b1);
      op(INS_DEBUGGER_BREAK_INSTR, 0);
      take(CLS_SPECIAL, {2'b00, SP_DEBUGGER_BREAK_INSTR}, 1'b1, 1'b1);
      op(INS_INTO, 0);
      quiet();
      flag <= 16'h0004;
      op(INS_INTO, 0);
      take(CLS_SPECIAL, {2'b00, SP_INTO}, 1'b1, 1'b1);
      k = int'(rnd() % 32'd34);
      wb(1, `ISC_A_LEVEL, 32'h300 | k);
      wb(0, `ISC_A_LEVEL, 0);
      check(rdat, 32'h300 | k);
      @(posedge clk);
      preq[k] <= 1'b1;
      @(posedge clk);
      preq <= '0;
      flag <= 16'h0000;
      quiet();
      flag <= 16'h3040;
      quiet();
      flag <= 16'h0040;
      take(CLS_PERIPH, 6'(k), 1'b1, 1'b0);
      flag <= 16'h0000;
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      take(CLS_SPECIAL, {2'b00, SP_WDT}, 1'b1, 1'b1);
      nmi_n <= 1'b0;
      take(CLS_SPECIAL, {2'b00, SP_NMI}, 1'b1, 1'b1);
      nmi_n <= 1'b1;
      drain();
      rst_pin_n <= 1'b0;
      take(CLS_SPECIAL, {2'b00, SP_RESET}, 1'b1, 1'b1);
      rst_pin_n <= 1'b1;
      drain();
      wb(1, `ISC_A_CTRL, 32'h1);
      fetch <= faddr;
      ist(faddr + 24'h1);
      quiet();
      ist(faddr);
      take(CLS_SPECIAL, {2'b00, SP_AMATCH}, 1'b1, 1'b1);
      wb(1, `ISC_A_CTRL, 32'h0);
      ist(faddr);
      quiet();
      flag <= 16'h0020;
      op(INS_NONE, 0);
      take(CLS_SPECIAL, {2'b00, SP_STEP}, 1'b1, 1'b1);
      flag <= 16'h0040;
      drain();
      wb(1, `ISC_A_LEVEL, 32'h122);
      wb(1, `ISC_A_LEVEL, 32'h125);
      wb(1, `ISC_A_LEVEL, 32'h126);
      key_n[0] <= 1'b0;
      take(CLS_PERIPH, 6'd37, 1'b1, 1'b0);
      key_n <= 4'hF;
      drain();
      for (int m = 0; m < 5; m++) begin
         p = !(m == `ISC_PM_FALL || m == `ISC_PM_LOW);
         ext[0] <= !p;
         wb(1, `ISC_A_PIN_MODE, m);
         drain();
         ext[0] <= p;
         take(CLS_PERIPH, 6'd38, 1'b1, 1'b0);
         ext[0] <= !p;
         drain();
      end
      wb(1, `ISC_A_SER_MODE, 32'h1);
      s_start[0] <= 1'b1;
      @(posedge clk);
      {s_start[0], s_stop[0]} <= 2'b01;
      @(posedge clk);
      s_stop[0] <= 1'b0;
      take(CLS_PERIPH, 6'd34, 1'b1, 1'b0);
      wb(1, `ISC_A_SER_MODE, 32'h10);
      drain();
      s_fault[0] <= 1'b1;
      @(posedge clk);
      s_fault[0] <= 1'b0;
      take(CLS_PERIPH, 6'd34, 1'b1, 1'b0);
      drain();
      k2 = (k + 1) % 34;
      faddr = rnd();
      pcv = rnd();
      fl = (rnd() & 16'h0F9F) | 16'h0040;
      {pc, flag} <= {pcv, fl};
      wb(1, `ISC_A_FVECT, {8'h00, faddr});
      wb(1, `ISC_A_EXIT_PRIO, 32'h8);
      // a single source at the top level and no transfer engines running
      wb(1, `ISC_A_LEVEL, 32'h700 | k2);
      @(posedge clk);
      preq[k2] <= 1'b1;
      n = 0;
      do begin @(posedge clk); preq <= '0; n++; end while (fast_entry !== 1'b1 && n < 20);
      check(n <= 7, 1'b1);
      check({ffa, sflag, spc}, {faddr, fl, pcv});
      drain();
      op(INS_FAST_RETURN_INSTR, 0);
      n = 1;
      do begin @(posedge clk); n++; end while (fast_restore !== 1'b1 && n < 20);
      check(n <= 4, 1'b1);
      repeat (2) @(posedge clk);
      check({rflag, rpc}, {fl, pcv});
      wb(1, `ISC_A_EXIT_PRIO, 32'h0);
      wb(1, `ISC_A_LEVEL, k2);
      drain();
      print_verdict();
   end
endmodule
